// ---- pkg/servo_io_pkg.sv ----
// Package with register map, field layouts and reset values of the servo sequence status block
package servo_io_pkg;
    // Register byte offsets
    localparam logic [7:0] ctrl_offset = 8'h00;
    localparam logic [7:0] width_offset = 8'h04;
    localparam logic [7:0] select_offset = 8'h08;
    localparam logic [7:0] status_offset = 8'h0c;
    // Field positions in ctrl register
    localparam int map_lsb = 0;
    localparam int mode_lsb = 4;
    // Field positions in width register
    localparam int pos_width_lsb = 0;
    localparam int spd_width_lsb = 8;
    // Values after reset, forced-on map code, width limits and pair count
    localparam logic [3:0] map_reset = 4'h0;
    localparam logic [3:0] map_forced_on = 4'h7;
    localparam logic [7:0] pos_width_reset = 8'h07;
    localparam logic [7:0] pos_width_max = 8'hfa;
    localparam logic [6:0] spd_width_reset = 7'h0a;
    localparam logic [6:0] spd_width_max = 7'h64;
    localparam logic [15:0] select_reset = 16'h3211;
    localparam int num_pairs = 3;

    // Control modes
    typedef enum logic [1:0] {
        mode_position = 2'b00,
        mode_speed = 2'b01,
        mode_torque = 2'b10
    } ctrl_mode_t;

    // Error samples from the control loop
    typedef struct packed {
        logic signed [31:0] position_error;
        logic signed [31:0] speed_reference;
        logic signed [31:0] motor_speed;
    } loop_sample_t;

    // Configuration carried to the comparator
    typedef struct packed {
        ctrl_mode_t mode;
        logic [7:0] pos_width;
        logic [6:0] spd_width;
    } cmp_cfg_t;
endpackage

// ---- hw/error_window.sv ----
// Absolute error comparator for position done and speed match
`timescale 1ns/10ps
module error_window
    import servo_io_pkg::*;
(
    input wire logic clk,
    input wire logic nrst,
    input wire loop_sample_t sample,
    input wire cmp_cfg_t cfg,
    output logic status_active
);
    logic [31:0] abs_pos;
    logic [31:0] abs_spd;
    logic signed [32:0] spd_diff;
    logic nxt_status;
    logic status_ff;

    // Absolute errors on each control cycle
    always_comb begin
        spd_diff = 33'(sample.speed_reference) - 33'(sample.motor_speed);
        abs_pos = sample.position_error[31] ? 32'(-sample.position_error) : 32'(sample.position_error);
        abs_spd = spd_diff[32] ? 32'(-spd_diff) : spd_diff[31:0];
    end

    // Mode picks which window drives the shared status
    always_comb begin
        case (cfg.mode)
            mode_position: nxt_status = abs_pos < {24'h000000, cfg.pos_width};
            mode_speed: nxt_status = abs_spd < {25'h0000000, cfg.spd_width};
            mode_torque: nxt_status = 1'b1;
            default: nxt_status = 1'b1;
        endcase
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            status_ff <= 1'b0;
        end else begin
            status_ff <= nxt_status;
        end
    end

    assign status_active = status_ff;
endmodule

// ---- hw/servo_sequence_io.sv ----
// Servo-on gating and shared status output with APB register access
//
// Notes on behaviour
// - Servo-on input low enables motor; high keeps motor off.
// - Mapping field 0 honours the servo-on input.
// - Mapping field 7 forces servo-on regardless of the input.
// - Position mode: done output low while position error below width.
// - Position width in reference units, 0 to 250, default 7.
// - Speed mode: match output low while speed error below width.
// - Speed width in rpm, 0 to 100, default 10.
// - Output select default 3211 puts shared status on first pair; relocatable.
// - Shared status: position done, speed match, or always on in torque.
//
// The implementer's own choices: the APB slave port and the address map.
`timescale 1ns/10ps
module servo_sequence_io
    import servo_io_pkg::*;
(
    input wire logic clk,
    input wire logic nrst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic servo_on_n,
    input wire loop_sample_t sample,
    output logic motor_enable,
    output logic [num_pairs-1:0] status_pair_n
);
    logic [3:0] map_ff;
    logic [3:0] nxt_map;
    ctrl_mode_t mode_ff;
    ctrl_mode_t nxt_mode;
    logic [7:0] pos_width_ff;
    logic [7:0] nxt_pos_width;
    logic [6:0] spd_width_ff;
    logic [6:0] nxt_spd_width;
    logic [15:0] select_ff;
    logic [15:0] nxt_select;
    logic [31:0] prdata_ff;
    logic [31:0] nxt_prdata;
    logic pready_ff;
    logic nxt_pready;
    logic pslverr_ff;
    logic nxt_pslverr;
    logic son_meta_ff;
    logic son_sync_ff;
    logic motor_ff;
    logic nxt_motor;
    logic [num_pairs-1:0] pair_n_ff;
    logic [num_pairs-1:0] nxt_pair_n;
    logic status_active;
    logic access;
    logic [3:0] done_sel;
    cmp_cfg_t cfg;
    logic wr_commit;
    logic ctrl_wr;
    logic width_wr;
    logic select_wr;
    ctrl_mode_t wr_mode;
    logic [7:0] wr_pos_width;
    logic [6:0] wr_spd_width;

    assign access = psel && penable && !pready_ff;
    assign done_sel = select_ff[3:0];
    assign cfg = '{mode: mode_ff, pos_width: pos_width_ff, spd_width: spd_width_ff};

    // Writes commit on the completing edge only, so a master that abandons a transfer changes nothing
    assign wr_commit = psel && penable && pready_ff && pwrite;
    assign ctrl_wr = wr_commit && (paddr == ctrl_offset);
    assign width_wr = wr_commit && (paddr == width_offset);
    assign select_wr = wr_commit && (paddr == select_offset);

    // Field decode of the write word; out-of-range widths clamp rather than wrap
    always_comb begin
        wr_mode = ctrl_mode_t'(pwdata[mode_lsb +: 2]);
        if (pwdata[mode_lsb +: 2] == 2'b11) begin
            wr_mode = mode_torque; // Unused code kept as torque so status never floats
        end
        wr_pos_width = pwdata[pos_width_lsb +: 8];
        if (pwdata[pos_width_lsb +: 8] > pos_width_max) begin
            wr_pos_width = pos_width_max;
        end
        wr_spd_width = pwdata[spd_width_lsb +: 7];
        if (pwdata[spd_width_lsb +: 7] > spd_width_max) begin
            wr_spd_width = spd_width_max;
        end
    end

    // Configuration next values
    always_comb begin
        nxt_map = map_ff;
        nxt_mode = mode_ff;
        nxt_pos_width = pos_width_ff;
        nxt_spd_width = spd_width_ff;
        nxt_select = select_ff;
        if (ctrl_wr) begin
            nxt_map = pwdata[map_lsb +: 4];
            nxt_mode = wr_mode;
        end
        if (width_wr) begin
            nxt_pos_width = wr_pos_width;
            nxt_spd_width = wr_spd_width;
        end
        if (select_wr) begin
            nxt_select = pwdata[15:0];
        end
    end

    // Configuration registers; reset gives the factory settings
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            map_ff <= map_reset;
            mode_ff <= mode_position;
            pos_width_ff <= pos_width_reset;
            spd_width_ff <= spd_width_reset;
            select_ff <= select_reset;
        end else begin
            map_ff <= nxt_map;
            mode_ff <= nxt_mode;
            pos_width_ff <= nxt_pos_width;
            spd_width_ff <= nxt_spd_width;
            select_ff <= nxt_select;
        end
    end

    // Read mux and response; one wait state keeps read data registered
    always_comb begin
        nxt_prdata = prdata_ff;
        nxt_pready = access;
        nxt_pslverr = 1'b0;
        if (access) begin
            case (paddr)
                ctrl_offset: begin
                    nxt_prdata = {26'h0, mode_ff, map_ff};
                end
                width_offset: begin
                    nxt_prdata = {17'h0, spd_width_ff, pos_width_ff};
                end
                select_offset: begin
                    nxt_prdata = {16'h0, select_ff};
                end
                status_offset: begin
                    nxt_prdata = {28'h0, son_sync_ff, motor_ff, status_active, 1'b0};
                end
                default: begin
                    nxt_prdata = 32'h0; // Unmapped reads return zero with an error
                    nxt_pslverr = 1'b1;
                end
            endcase
        end
    end

    // Bus response registers
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            prdata_ff <= 32'h0;
            pready_ff <= 1'b0;
            pslverr_ff <= 1'b0;
        end else begin
            prdata_ff <= nxt_prdata;
            pready_ff <= nxt_pready;
            pslverr_ff <= nxt_pslverr;
        end
    end

    // Two-stage synchroniser; input high (open) at reset means servo off
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            son_meta_ff <= 1'b1;
            son_sync_ff <= 1'b1;
        end else begin
            son_meta_ff <= servo_on_n;
            son_sync_ff <= son_meta_ff;
        end
    end

    // Servo enable; other map values fall back to honouring the pin
    always_comb begin
        if (map_ff == map_forced_on) begin
            nxt_motor = 1'b1;
        end else begin
            nxt_motor = !son_sync_ff;
        end
    end

    error_window u_window (
        .clk(clk),
        .nrst(nrst),
        .sample(sample),
        .cfg(cfg),
        .status_active(status_active)
    );

    // Pair k is driven low while status is active and select code equals k+1; code 0 drives no pair
    genvar k;
    generate
        for (k = 0; k < num_pairs; k++) begin : g_pair
            assign nxt_pair_n[k] = !(status_active && (done_sel == 4'(k + 1)));
        end
    endgenerate

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            motor_ff <= 1'b0;
            pair_n_ff <= '1;
        end else begin
            motor_ff <= nxt_motor;
            pair_n_ff <= nxt_pair_n;
        end
    end

    assign motor_enable = motor_ff;
    assign status_pair_n = pair_n_ff;
    assign prdata = prdata_ff;
    assign pready = pready_ff;
    assign pslverr = pslverr_ff;
endmodule

// ---- verif/servo_io_chk.sv ----
// Port timing checker for the servo sequence block
`timescale 1ns/10ps
module servo_io_chk
    import servo_io_pkg::*;
(
    input wire logic clk,
    input wire logic nrst,
    input wire logic psel,
    input wire logic penable,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic servo_on_n,
    input wire logic motor_enable,
    input wire logic [num_pairs-1:0] status_pair_n
);
    default clocking @(posedge clk); endclocking
    default disable iff (!nrst);
    // Pin low long enough always wins, whatever the mapping
    a_servo_follow: assert property (!servo_on_n [*4] |=> motor_enable)
        else $error("motor not on");
    // Two sync stages plus output stage before a drop
    a_servo_drop: assert property ($fell(motor_enable) |-> $past(servo_on_n, 3))
        else $error("motor dropped early");
    a_reset_state: assert property ($rose(nrst) |-> status_pair_n == 3'b111 && !motor_enable)
        else $error("bad state after reset");
    a_single_pair: assert property ($countones(~status_pair_n) <= 1)
        else $error("status on two pairs");
    // Exactly one wait state in every access
    a_one_wait: assert property (psel && penable && !pready |=> pready)
        else $error("pready late");
    a_ready_pulse: assert property (pready |=> !pready)
        else $error("pready too long");
    a_ready_access: assert property (pready |-> psel && penable)
        else $error("pready outside access");
    a_error_zero: assert property (pslverr |-> pready && prdata == 32'h0)
        else $error("bad error response");
endmodule
bind servo_sequence_io servo_io_chk chk_u (.clk(clk), .nrst(nrst), .psel(psel), .penable(penable),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .servo_on_n(servo_on_n),
    .motor_enable(motor_enable), .status_pair_n(status_pair_n));

// ---- verif/host_model.sv ----
// Host controller model: servo-on command and done interlock
`timescale 1ns/10ps
module host_model (
    input wire logic clk,
    input wire logic run_req,
    input wire logic done_n,
    output logic servo_on_n = 1'b1,
    output logic move_done = 1'b0
);
    // Pin follows the command only; motion is left to references
    always @(posedge clk) begin
        servo_on_n <= !run_req;
        move_done <= !done_n;
    end
endmodule

// ---- verif/tb.sv ----
// Self-checking bench for the servo sequence block
`timescale 1ns/10ps
module tb;
    import servo_io_pkg::*;
    typedef struct {logic [1:0] mode; logic [15:0] wd; int pe, sr, ms; logic [2:0] exp;} row_t;
    logic clk = 1'b0, nrst = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, run_req = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic pready, pslverr, servo_on_n, motor_enable, move_done, err;
    logic [2:0] status_pair_n;
    loop_sample_t sample = '0;
    int mismatches = 0, compares = 0, cycles = 0;
    // Mode, widths, errors, expected pairs; width equality counts as not reached
    row_t rows[8] = '{'{0, 16'h0a07, 6, 0, 500, 3'b110}, '{0, 16'h0a07, -7, 0, 0, 3'b111},
        '{0, 16'h0afa, -249, 0, 0, 3'b110}, '{0, 16'h0a00, 0, 0, 0, 3'b111},
        '{1, 16'h0a07, 90, 2000, 1991, 3'b110}, '{1, 16'h0a07, 0, 2000, 2010, 3'b111},
        '{1, 16'h6407, 0, 2000, 2099, 3'b110}, '{2, 16'h0000, 1000, 9, 0, 3'b110}};
    servo_sequence_io dut_u (.clk(clk), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .servo_on_n(servo_on_n), .sample(sample), .motor_enable(motor_enable), .status_pair_n(status_pair_n));
    host_model host_u (.clk(clk), .run_req(run_req), .done_n(status_pair_n[0]), .servo_on_n(servo_on_n),
        .move_done(move_done));
    always #4 clk = ~clk;
    task chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            mismatches++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // Master holds the request until pready is seen at an edge
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask
    task summarize;
        if (mismatches == 0 && compares > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    // Cuts a hang short
    always @(posedge clk) begin
        cycles++;
        if (cycles == 3000) begin
            mismatches++;
            summarize();
        end
    end
    initial begin
        repeat (4) @(posedge clk);
        nrst <= 1'b1;
        apb(1'b0, width_offset, 32'h0);
        chk(rd, 32'h0a07);
        apb(1'b0, select_offset, 32'h0);
        chk(rd, 32'h3211);
        apb(1'b0, 8'h10, 32'h0);
        chk(err, 1'b1);
        // Widths past range must stay inside it
        apb(1'b1, width_offset, 32'hffff);
        apb(1'b0, width_offset, 32'h0);
        chk(rd, 32'h64fa);
        foreach (rows[i]) begin
            apb(1'b1, ctrl_offset, {26'h0, rows[i].mode, 4'h0});
            apb(1'b1, width_offset, {16'h0, rows[i].wd});
            sample <= '{rows[i].pe, rows[i].sr, rows[i].ms};
            repeat (4) @(posedge clk);
            chk(status_pair_n, rows[i].exp);
            chk(move_done, !rows[i].exp[0]);
        end
        apb(1'b0, status_offset, 32'h0);
        chk(rd[1], 1'b1);
        // Relocate the shared status, then switch it off
        apb(1'b1, select_offset, 32'h3212);
        repeat (3) @(posedge clk);
        chk(status_pair_n, 3'b101);
        apb(1'b1, select_offset, 32'h3210);
        repeat (3) @(posedge clk);
        chk(status_pair_n, 3'b111);
        chk(motor_enable, 1'b0);
        run_req <= 1'b1;
        repeat (6) @(posedge clk);
        chk(motor_enable, 1'b1);
        run_req <= 1'b0;
        repeat (6) @(posedge clk);
        chk(motor_enable, 1'b0);
        apb(1'b1, ctrl_offset, 32'h27);
        repeat (4) @(posedge clk);
        chk(motor_enable, 1'b1);
        // Second reset in mid-run; mapping, widths and selection return to factory values
        nrst <= 1'b0;
        @(posedge clk);
        chk(motor_enable, 1'b0);
        chk(status_pair_n, 3'b111);
        nrst <= 1'b1;
        apb(1'b0, width_offset, 32'h0);
        chk(rd, 32'h0a07);
        apb(1'b0, select_offset, 32'h0);
        chk(rd, 32'h3211);
        repeat (2) @(posedge clk);
        chk(motor_enable, 1'b0);
        chk(status_pair_n, 3'b111);
        // Unused mode code reads back as torque; map 5 still honours the pin
        apb(1'b1, ctrl_offset, 32'h35);
        apb(1'b0, ctrl_offset, 32'h0);
        chk(rd, 32'h25);
        apb(1'b1, select_offset, 32'h3213);
        repeat (3) @(posedge clk);
        chk(status_pair_n, 3'b011);
        chk(motor_enable, 1'b0);
        run_req <= 1'b1;
        repeat (6) @(posedge clk);
        chk(motor_enable, 1'b1);
        summarize();
    end
endmodule
